// [rtl/dqps_map.vh]
// constants for the strobe phase-shift capture block
`ifndef DQPS_MAP_VH
`define DQPS_MAP_VH
`define DQPS_CODE_W      6
`define DQPS_CODE_RST    6'h00
`define DQPS_SRC_W       3
`define DQPS_SRC_PLL     3'h4
`define DQPS_TOP_PLL     3'h5
`define DQPS_BOT_PLL     3'h6
`define DQPS_MODE_W      3
`define DQPS_MODE_X4     3'h0
`define DQPS_MODE_X8     3'h1
`define DQPS_MODE_X9     3'h2
`define DQPS_MODE_X16    3'h3
`define DQPS_MODE_X18    3'h4
`define DQPS_MODE_X32    3'h5
`define DQPS_MODE_X36    3'h6
`define DQPS_MAX_PAIRS   18
`define DQPS_MAX_SIDE_A  10
`define DQPS_MAX_SIDE_B  8
`define DQPS_BANK_TOP0   3
`define DQPS_BANK_TOP1   4
`define DQPS_BANK_BOT0   7
`define DQPS_BANK_BOT1   8
`define DQPS_LOCK_CNT    8'h04
`endif

// [rtl/dqps_buf2.v]
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module dqps_buf2 #(
    parameter W = 72
) (
    // clock and reset
    input  wire         i_ref_clk,
    input  wire         i_arst_n,
    // fill side
    input  wire         i_valid,
    input  wire [W-1:0] i_data,
    output wire         o_ready,
    // drain side
    output wire         o_valid,
    output wire [W-1:0] o_data,
    input  wire         i_ready
);
    reg [W-1:0] mem_reg [0:1];
    reg         wp_reg;
    reg         rp_reg;
    reg [1:0]   cnt_reg;
    wire        push = i_valid && (cnt_reg != 2'h2);
    wire        pop  = i_ready && (cnt_reg != 2'h0);

    assign o_ready = (cnt_reg != 2'h2);
    assign o_valid = (cnt_reg != 2'h0);
    assign o_data  = mem_reg[rp_reg];

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_reg    <= 1'b0;
            rp_reg    <= 1'b0;
            cnt_reg   <= 2'h0;
            mem_reg[0] <= {W{1'b0}};
            mem_reg[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_reg[wp_reg] <= i_data;
                wp_reg          <= ~wp_reg;
            end
            if (pop)
                rp_reg <= ~rp_reg;
            if (push && !pop)
                cnt_reg <= cnt_reg + 2'h1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule // dqps_buf2
`default_nettype wire

// [rtl/dqps_edge_capture.v]
// one edge of strobe phase-shift capture: reference controller, delays and ddr capture
`timescale 1ns/100ps
`default_nettype none
`include "dqps_map.vh"
module dqps_edge_capture #(
    parameter       NGRP    = 4,
    parameter       DW      = 36,
    parameter [2:0] OWN_PLL = `DQPS_TOP_PLL,
    parameter       MAXD    = 63
) (
    // clock and reset
    input  wire                    i_ref_clk,
    input  wire                    i_arst_n,
    // reference selection
    input  wire [3:0]              i_pin_ref,
    input  wire [`DQPS_SRC_W-1:0]  i_ref_sel,
    input  wire [`DQPS_SRC_W-1:0]  i_pll_id,
    input  wire                    i_pll_ref,
    // group configuration
    input  wire [`DQPS_MODE_W-1:0] i_mode,
    input  wire [3:0]              i_bank,
    input  wire [NGRP-1:0]         i_side_b,
    // memory pins
    input  wire [NGRP-1:0]         i_strobe,
    input  wire [NGRP*DW-1:0]      i_dq,
    // captured words
    output wire                    o_valid,
    output wire [2*NGRP*DW-1:0]    o_data,
    input  wire                    i_ready,
    // status
    output reg  [`DQPS_CODE_W-1:0] o_code,
    output reg                     o_locked,
    output wire                    o_cfg_err,
    output wire [NGRP-1:0]         o_local_strobe
);
    localparam ST_SEARCH = 1'b0;
    localparam ST_TRACK  = 1'b1;

    // reference source: own pin group or the one permitted pll
    wire pll_ok  = (i_pll_id == OWN_PLL);
    reg  ref_raw;
    // out-of-range selects give no reference at all
    always @* begin
        case (i_ref_sel)
            3'h0, 3'h1, 3'h2, 3'h3: ref_raw = i_pin_ref[i_ref_sel[1:0]];
            `DQPS_SRC_PLL:          ref_raw = i_pll_ref & pll_ok;
            default:                ref_raw = 1'b0;
        endcase
    end
    wire bank_ok = (i_bank == `DQPS_BANK_TOP0) || (i_bank == `DQPS_BANK_TOP1) ||
                   (i_bank == `DQPS_BANK_BOT0) || (i_bank == `DQPS_BANK_BOT1);
    integer k;
    reg [4:0] nb_reg;
    always @* begin
        nb_reg = 5'h00;
        for (k = 0; k < NGRP; k = k + 1)
            nb_reg = nb_reg + {4'h0, i_side_b[k]};
    end
    wire pairs_ok = (NGRP <= `DQPS_MAX_PAIRS) && (nb_reg <= `DQPS_MAX_SIDE_B) &&
                    ((NGRP - nb_reg) <= `DQPS_MAX_SIDE_A);
    wire src_ok   = (i_ref_sel[2] == 1'b0) || (i_ref_sel == `DQPS_SRC_PLL && pll_ok);
    assign o_cfg_err = !(bank_ok && pairs_ok && src_ok && i_mode <= `DQPS_MODE_X36);

    // reference synchroniser and period measurement
    reg ref_s1_reg, ref_s2_reg, ref_s3_reg;
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_raw;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end
    wire ref_rise = ref_s2_reg & ~ref_s3_reg;

    reg [`DQPS_CODE_W-1:0] per_reg;
    // quarter-period delay code, one value for the whole edge
    wire [`DQPS_CODE_W-1:0] code_next = {2'b00, per_reg[`DQPS_CODE_W-1:2]};
    reg [7:0]              stable_reg;
    reg                    state_reg;
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            per_reg    <= `DQPS_CODE_RST;
            o_code     <= `DQPS_CODE_RST;
            stable_reg <= 8'h00;
            state_reg  <= ST_SEARCH;
            o_locked   <= 1'b0;
        end else if (ref_rise) begin
            // the rise cycle counts too, so a period of n clocks gives n/4
            per_reg <= 6'h01;
            o_code  <= code_next;
            case (state_reg)
                ST_SEARCH: begin
                    if (code_next == o_code && code_next != `DQPS_CODE_RST)
                        stable_reg <= stable_reg + 8'h01;
                    else
                        stable_reg <= 8'h00;
                    if (stable_reg == `DQPS_LOCK_CNT) begin
                        state_reg <= ST_TRACK;
                        o_locked  <= 1'b1;
                    end
                end
                ST_TRACK: begin
                    if (code_next == `DQPS_CODE_RST) begin
                        state_reg  <= ST_SEARCH;
                        o_locked   <= 1'b0;
                        stable_reg <= 8'h00;
                    end
                end
                default: state_reg <= ST_SEARCH;
            endcase
        end else if (per_reg != {`DQPS_CODE_W{1'b1}}) begin
            per_reg <= per_reg + 6'h01;
        end
    end

    // per-group delay, local strobe net and ddr capture
    wire [2*NGRP*DW-1:0] word_all;
    wire [NGRP-1:0]      ev_all;
    reg  [35:0]          mask_full;
    wire [DW-1:0]        mask = mask_full[DW-1:0];
    // width mask, cut to the group width actually built
    always @* begin
        case (i_mode)
            `DQPS_MODE_X4:  mask_full = 36'h0_0000_000f;
            `DQPS_MODE_X8:  mask_full = 36'h0_0000_00ff;
            `DQPS_MODE_X9:  mask_full = 36'h0_0000_01ff;
            `DQPS_MODE_X16: mask_full = 36'h0_0000_ffff;
            `DQPS_MODE_X18: mask_full = 36'h0_0003_ffff;
            `DQPS_MODE_X32: mask_full = 36'h0_ffff_ffff;
            default:        mask_full = 36'hf_ffff_ffff;
        endcase
    end
    genvar g;
    generate
        for (g = 0; g < NGRP; g = g + 1) begin : grp
            reg [1:0]    ss_reg;
            reg [MAXD:0] dl_reg;
            reg          dq_prev_reg;
            reg          ev_reg;
            reg [DW-1:0] dq1_reg, dq2_reg, hi_reg, lo_reg, latch_reg;
            wire         lstrobe = dl_reg[o_code];
            assign o_local_strobe[g]          = lstrobe;
            assign ev_all[g]                  = ev_reg;
            assign word_all[g*2*DW +: 2*DW] = {latch_reg, lo_reg};
            always @(posedge i_ref_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ss_reg      <= 2'b00;
                    dl_reg      <= {(MAXD+1){1'b0}};
                    dq_prev_reg <= 1'b0;
                    dq1_reg     <= {DW{1'b0}};
                    dq2_reg     <= {DW{1'b0}};
                    hi_reg      <= {DW{1'b0}};
                    lo_reg      <= {DW{1'b0}};
                    latch_reg   <= {DW{1'b0}};
                    ev_reg      <= 1'b0;
                end else begin
                    ss_reg      <= {ss_reg[0], i_strobe[g]};
                    dl_reg      <= {dl_reg[MAXD-1:0], ss_reg[1]};
                    dq1_reg     <= i_dq[g*DW +: DW];
                    dq2_reg     <= dq1_reg;
                    dq_prev_reg <= lstrobe;
                    ev_reg      <= 1'b0;
                    if (lstrobe && !dq_prev_reg)
                        hi_reg <= dq2_reg & mask;
                    if (!lstrobe && dq_prev_reg) begin
                        lo_reg    <= dq2_reg & mask;
                        latch_reg <= hi_reg;
                        ev_reg    <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    dqps_buf2 #(.W(2*NGRP*DW)) u_buf (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_valid   (ev_all[0] && o_locked && !o_cfg_err),
        .i_data    (word_all),
        .o_ready   (),
        .o_valid   (o_valid),
        .o_data    (o_data),
        .i_ready   (i_ready)
    );
endmodule // dqps_edge_capture
`default_nettype wire

// [tb/dqps_properties.sv]
// assertions on one edge of strobe capture
`timescale 1ns/100ps
`default_nettype none
`include "dqps_map.vh"
module dqps_chk #(parameter NGRP = 4, parameter DW = 36, parameter [2:0] OWN_PLL = `DQPS_TOP_PLL) (
    input wire logic                    i_ref_clk,
    input wire logic                    i_arst_n,
    input wire logic [`DQPS_SRC_W-1:0]  i_ref_sel,
    input wire logic [`DQPS_SRC_W-1:0]  i_pll_id,
    input wire logic [`DQPS_MODE_W-1:0] i_mode,
    input wire logic [3:0]              i_bank,
    input wire logic                    i_ready,
    input wire logic                    o_valid,
    input wire logic [2*NGRP*DW-1:0]    o_data,
    input wire logic [`DQPS_CODE_W-1:0] o_code,
    input wire logic                    o_locked,
    input wire logic                    o_cfg_err
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_held; o_valid && $stable(o_data); endsequence
    property p_hold; o_valid && !i_ready |=> s_held; endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    property p_bank; !(i_bank inside {4'h3, 4'h4, 4'h7, 4'h8}) |-> o_cfg_err; endproperty
    a_bank: assert property (p_bank) else $error("side bank accepted");
    property p_mode; i_mode > `DQPS_MODE_X36 |-> o_cfg_err; endproperty
    a_mode: assert property (p_mode) else $error("bad width accepted");
    property p_sel; i_ref_sel > `DQPS_SRC_PLL |-> o_cfg_err; endproperty
    a_sel: assert property (p_sel) else $error("bad source accepted");
    property p_pll; i_ref_sel == `DQPS_SRC_PLL && i_pll_id != OWN_PLL |-> o_cfg_err; endproperty
    a_pll: assert property (p_pll) else $error("foreign pll accepted");
    property p_vlock; $rose(o_valid) |-> $past(o_locked); endproperty
    a_vlock: assert property (p_vlock) else $error("word before lock");
    property p_lock; $rose(o_locked) |-> o_code != 6'h00; endproperty
    a_lock: assert property (p_lock) else $error("locked on zero code");
    property p_rst; $rose(i_arst_n) |-> !o_locked && !o_valid && o_code == 6'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule // dqps_chk
bind dqps_edge_capture dqps_chk #(.NGRP(NGRP), .DW(DW), .OWN_PLL(OWN_PLL)) chk_u (.i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n), .i_ref_sel(i_ref_sel), .i_pll_id(i_pll_id), .i_mode(i_mode), .i_bank(i_bank),
    .i_ready(i_ready), .o_valid(o_valid), .o_data(o_data), .o_code(o_code), .o_locked(o_locked),
    .o_cfg_err(o_cfg_err));
`default_nettype wire

// [tb/dqps_mem_model.sv]
// memory read side: edge-aligned strobe and data
`timescale 1ns/100ps
`default_nettype none
module dqps_mem_model #(parameter DW = 4) (
    input  wire logic          i_clk,
    output logic               o_strobe,
    output logic [DW-1:0]      o_dq
);
    initial begin
        o_strobe = 1'b0;
        o_dq = '0;
    end
    // one 320 ns strobe period; idle data shows the inverse of its last value
    task automatic burst(input logic [DW-1:0] hi, input logic [DW-1:0] lo, input bit last);
        o_dq = hi;
        o_strobe = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_dq = lo;
        o_strobe = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 if (last) o_dq = ~lo;
    endtask
endmodule // dqps_mem_model
`default_nettype wire

// [tb/tb_top.sv]
// testbench for one strobe capture edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       i_ref_clk = 1'b0, i_arst_n = 1'b0, refc = 1'b0, i_ready = 1'b0, i_side_b = 1'b0;
    logic [2:0] i_ref_sel = 3'h0, i_pll_id = 3'h5, i_mode = 3'h0;
    logic [3:0] i_bank = 4'h3;
    wire        strobe, o_valid, o_locked, o_cfg_err, lstr;
    wire [3:0]  dq;
    wire [7:0]  o_data;
    wire [5:0]  o_code;
    int         err_count = 0, num_checks = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    initial #7 forever #160 refc = ~refc;
    dqps_mem_model #(.DW(4)) mem_u (.i_clk(i_ref_clk), .o_strobe(strobe), .o_dq(dq));
    dqps_edge_capture #(.NGRP(1), .DW(4)) dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
        .i_pin_ref({4{refc}}), .i_ref_sel(i_ref_sel), .i_pll_id(i_pll_id), .i_pll_ref(refc), .i_mode(i_mode),
        .i_bank(i_bank), .i_side_b(i_side_b), .i_strobe(strobe), .i_dq(dq), .o_valid(o_valid), .o_data(o_data),
        .i_ready(i_ready), .o_code(o_code), .o_locked(o_locked), .o_cfg_err(o_cfg_err), .o_local_strobe(lstr));
    task automatic conclude();
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input bit lock);
        int n = 0;
        while ((lock ? o_locked : o_valid) !== 1'b1 && n < 400) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        if (n == 400) begin
            err_count++;
            $display("mismatch %0t wait ran out", $time);
            conclude();
        end
    endtask
    task automatic pop(input logic [7:0] exp);
        wait_for(0);
        chk(o_data, exp);
        i_ready = 1'b1;
        @(posedge i_ref_clk);
        #1 i_ready = 1'b0;
        // one idle edge so a following pop never re-raises ready in the same step
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic s_lock(input logic [2:0] sel, input logic [2:0] pll);
        i_ref_sel = sel;
        i_pll_id = pll;
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h00, o_cfg_err}, 8'h00);
        // three reference periods so the code settles after a source change
        repeat (24) @(posedge i_ref_clk);
        #1 wait_for(1);
        chk({2'b00, o_code}, 8'h02);
    endtask
    task automatic s_stall();
        mem_u.burst(4'hA, 4'h5, 0);
        mem_u.burst(4'h3, 4'hC, 0);
        mem_u.burst(4'h9, 4'h6, 1);
        chk({7'h00, lstr}, 8'h01);
        repeat (12) @(posedge i_ref_clk);
        #1 pop(8'hA5);
        pop(8'h3C);
        repeat (4) @(posedge i_ref_clk);
        #1 chk({7'h00, o_valid}, 8'h00);
    endtask
    task automatic s_cfg();
        logic [12:0] bad [4] = '{{4'h5, 3'h0, 3'h0, 3'h5}, {4'h3, 3'h7, 3'h0, 3'h5},
                                 {4'h3, 3'h0, 3'h5, 3'h5}, {4'h8, 3'h0, 3'h4, 3'h6}};
        foreach (bad[k]) begin
            {i_bank, i_mode, i_ref_sel, i_pll_id} = bad[k];
            @(posedge i_ref_clk);
            #1 chk({7'h00, o_cfg_err}, 8'h01);
        end
        mem_u.burst(4'h1, 4'h2, 1);
        repeat (12) @(posedge i_ref_clk);
        #1 chk({7'h00, o_valid}, 8'h00);
        {i_bank, i_mode} = {4'h7, 3'h6};
    endtask
    initial begin
        repeat (3) @(posedge i_ref_clk);
        #1 i_arst_n = 1'b1;
        chk({o_valid, o_locked, o_code}, 8'h00);
        for (int s = 0; s < 4; s++) s_lock(s[2:0], 3'h5);
        s_stall();
        s_cfg();
        s_lock(3'h4, 3'h5);
        mem_u.burst(4'hF, 4'h0, 1);
        pop(8'hF0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
